// *** src/dft_ctl.sv ***
// DMA FIFO threshold, dual-address and interrupt control block with APB slave
// Summary of operation
// - Ch0 inbound almost-full code gates the local-bus write request.
// - Ch0 outbound almost-empty code gates the local-bus read request.
// - Ch0 outbound almost-full code gates the PCI-bus write request.
// - Ch0 inbound almost-empty code gates the PCI-bus read request.
// - Ch1 inbound pair: almost-full local write, almost-empty PCI read.
// - Ch1 outbound pair: almost-empty local read, almost-full PCI write.
// - Codes decode to longwords per table: 4 up to 60, with 38 and 58.
// - Upper address register; zero selects plain 32-bit DMA addressing.
// - Bit 0 routes local parity error or PCI abort to local error output.
// - Bit 1 routes SERR, PCI parity or queue overflow to local error output.
// - Writing one to bit 2 while zero asserts PCI SERR.
// - Mailbox write raises local interrupt when enabled; mailbox read clears it.
// - Bit 4 raises local interrupt on power-state change.
// - Bit 5 pending on power-state change; write one clears, PCI only in D0.
// - Bit 16 enables local interrupt output, resets to one.
`timescale 1ns/1ps
module dft_ctl
	import dft_pkg::*;
(
	input  wire logic          clock,           // System clock
	input  wire logic          rst_n,           // Async reset, active low
	input  wire logic          psel,            // APB select
	input  wire logic          penable,         // APB enable
	input  wire logic          pwrite,          // APB direction
	input  wire logic [7:0]    paddr,           // APB byte address
	input  wire logic [31:0]   pwdata,          // APB write data
	input  wire logic          pwrite_pci,      // Write comes from PCI side
	output logic               pready,          // APB ready
	output logic [31:0]        prdata,          // APB read data
	output logic               pslverr,         // APB error
	input  wire dft_pkg::dft_level_t fifo_level,// FIFO fill/free counts
	input  wire logic [3:0]    xfer_start,      // Transfer begun: ch0 lw,lr,pw,pr? see order
	input  wire logic [3:0]    xfer_start_ch1,  // Transfer begun for ch1
	output logic [3:0]         req_ch0_r,       // Ch0: local wr, local rd, pci wr, pci rd
	output logic [3:0]         req_ch1_r,       // Ch1: local wr, local rd, pci wr, pci rd
	output logic [31:0]        dual_addr_upper, // Upper DMA address
	output logic               dual_addr_en,    // Dual address cycles in use
	input  wire logic          local_parity_err,// Local parity error event
	input  wire logic          pci_abort,       // PCI abort event
	input  wire logic          host_serr_seen,  // SERR seen in host mode
	input  wire logic          pci_parity_err,  // PCI parity error event
	input  wire logic          queue_overflow,  // Outbound queue overflow
	input  wire logic          mailbox_write,   // PCI wrote a mailbox
	input  wire logic          mailbox_read,    // Local master read a mailbox
	input  wire logic [1:0]    power_state,     // Power state bits
	output logic               local_system_error_out, // Local error output
	output logic               pci_serr_out,    // PCI SERR assert
	output logic               local_interrupt_out,    // Local interrupt out
	output logic               irq              // Combined interrupt
);
	import dft_pkg::*;

	dft_thresh_t          thresh_r;
	logic [31:0]          dual_r;
	logic [31:0]          ctl_r;
	logic                 mbox_pend_r;
	logic                 serr_r;
	logic [1:0]           pstate_r;
	logic [DFT_EV_N-1:0]  stat_r;
	logic [DFT_EV_N-1:0]  mask_r;
	logic [DFT_NCMP-1:0]  hit;
	logic [DFT_NCMP-1:0]  start_all;
	dft_req_state_t       st_r [DFT_NCMP];
	logic                 wr_en;
	logic                 rd_en;
	logic                 pm_change;
	logic                 pm_clr;
	logic [DFT_EV_N-1:0]  ev_set;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pslverr = psel && penable && !(paddr == DFT_OFF_THRESH || paddr == DFT_OFF_DUAL_UP
		|| paddr == DFT_OFF_INTCTL || paddr == DFT_OFF_IRQ_STAT || paddr == DFT_OFF_IRQ_MASK
		|| paddr == DFT_OFF_REQ_STAT);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= DFT_ZERO;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				DFT_OFF_THRESH:   prdata <= thresh_r;
				DFT_OFF_DUAL_UP:  prdata <= dual_r;
				DFT_OFF_INTCTL:   prdata <= ctl_r;
				DFT_OFF_IRQ_STAT: prdata <= {29'h0000_0000, stat_r};
				DFT_OFF_IRQ_MASK: prdata <= {29'h0000_0000, mask_r};
				DFT_OFF_REQ_STAT: prdata <= {24'h00_0000, req_ch1_r, req_ch0_r};
				default:          prdata <= DFT_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Threshold and upper address registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			thresh_r <= dft_thresh_t'(DFT_ZERO);
			dual_r   <= DFT_ZERO;
		end else if (wr_en) begin
			if (paddr == DFT_OFF_THRESH)  thresh_r <= pwdata;
			if (paddr == DFT_OFF_DUAL_UP) dual_r   <= pwdata;
		end
	end
	assign dual_addr_upper = dual_r;
	assign dual_addr_en    = (dual_r != DFT_ZERO);

	// ----------------------------------------------------------------
	// Threshold compare and held requests
	// ----------------------------------------------------------------
	always_comb begin
		hit[0] = fifo_level.ch0_in_fill  >= dft_decode(thresh_r.ch0_inbound_almost_full);
		hit[1] = fifo_level.ch0_out_free >= dft_decode(thresh_r.ch0_outbound_almost_empty);
		hit[2] = fifo_level.ch0_out_fill >= dft_decode(thresh_r.ch0_outbound_almost_full);
		hit[3] = fifo_level.ch0_in_free  >= dft_decode(thresh_r.ch0_inbound_almost_empty);
		hit[4] = fifo_level.ch1_in_fill  >= dft_decode(thresh_r.ch1_inbound_almost_full);
		hit[5] = fifo_level.ch1_out_free >= dft_decode(thresh_r.ch1_outbound_almost_empty);
		hit[6] = fifo_level.ch1_out_fill >= dft_decode(thresh_r.ch1_outbound_almost_full);
		hit[7] = fifo_level.ch1_in_free  >= dft_decode(thresh_r.ch1_inbound_almost_empty);
	end
	assign start_all = {xfer_start_ch1, xfer_start};

	for (genvar i = 0; i < DFT_NCMP; i++) begin : g_req
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				st_r[i] <= DFT_IDLE;
			end else begin
				unique case (st_r[i])
					DFT_IDLE: if (hit[i]) st_r[i] <= DFT_REQ;
					DFT_REQ:  if (start_all[i]) st_r[i] <= DFT_IDLE;
					default:  st_r[i] <= DFT_IDLE;
				endcase
			end
		end
	end
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			req_ch0_r[k] = (st_r[k] == DFT_REQ);
			req_ch1_r[k] = (st_r[k+4] == DFT_REQ);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt control register
	// ----------------------------------------------------------------
	assign pm_change = (power_state != pstate_r);
	assign pm_clr    = wr_en && paddr == DFT_OFF_INTCTL && pwdata[DFT_B_PM_PEND]
		&& !(pwrite_pci && power_state != DFT_PM_D0);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pstate_r <= DFT_PM_D0;
		end else begin
			pstate_r <= power_state;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= DFT_INTCTL_RST;
		end else begin
			if (wr_en && paddr == DFT_OFF_INTCTL) begin
				ctl_r[4:0]          <= pwdata[4:0];
				ctl_r[DFT_B_LINT_EN] <= pwdata[DFT_B_LINT_EN];
			end
			if (pm_change) ctl_r[DFT_B_PM_PEND] <= 1'b1;
			else if (pm_clr) ctl_r[DFT_B_PM_PEND] <= 1'b0;
		end
	end

	// SERR pulse only on a zero-to-one write of bit 2
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			serr_r <= 1'b0;
		end else begin
			serr_r <= wr_en && paddr == DFT_OFF_INTCTL && pwdata[DFT_B_GEN_SERR]
				&& !ctl_r[DFT_B_GEN_SERR];
		end
	end
	assign pci_serr_out = serr_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mbox_pend_r <= 1'b0;
		end else if (mailbox_write) begin
			mbox_pend_r <= 1'b1;
		end else if (mailbox_read) begin
			mbox_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			local_system_error_out <= 1'b0;
			local_interrupt_out    <= 1'b0;
		end else begin
			local_system_error_out <= (ctl_r[DFT_B_SERR_LOCAL] && (local_parity_err || pci_abort))
				|| (ctl_r[DFT_B_SERR_PCI] && (host_serr_seen || pci_parity_err || queue_overflow));
			local_interrupt_out <= ctl_r[DFT_B_LINT_EN] &&
				((ctl_r[DFT_B_MBOX_EN] && mbox_pend_r)
				|| (ctl_r[DFT_B_PM_EN] && ctl_r[DFT_B_PM_PEND]));
		end
	end

	// ----------------------------------------------------------------
	// Sticky event status and mask
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= '0;
			mask_r <= '0;
		end else begin
			if (wr_en && paddr == DFT_OFF_IRQ_MASK) mask_r <= pwdata[DFT_EV_N-1:0];
			for (int e = 0; e < DFT_EV_N; e++) begin
				if (ev_set[e]) stat_r[e] <= 1'b1;
				else if (wr_en && paddr == DFT_OFF_IRQ_STAT && pwdata[e]) stat_r[e] <= 1'b0;
			end
		end
	end
	assign ev_set = {serr_r, pm_change, mailbox_write};
	assign irq    = |(stat_r & mask_r);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	serr_gen_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_en && paddr == DFT_OFF_INTCTL && pwdata[DFT_B_GEN_SERR] && !ctl_r[DFT_B_GEN_SERR] |=> pci_serr_out)
		else $error("SERR not generated");
	dual_en_a: assert property (@(posedge clock) disable iff (!rst_n)
		dual_addr_en == (dual_addr_upper != 32'h0000_0000)) else $error("Dual address enable wrong");
	pm_pend_a: assert property (@(posedge clock) disable iff (!rst_n)
		pm_change |=> ctl_r[DFT_B_PM_PEND]) else $error("PM pending not set");
	lint_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctl_r[DFT_B_LINT_EN] |=> !local_interrupt_out) else $error("Local interrupt not gated");
	mbox_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
		mailbox_write && ctl_r[DFT_B_MBOX_EN] && ctl_r[DFT_B_LINT_EN] && !mailbox_read
		&& $stable(ctl_r) ##1 $stable(ctl_r) |=> ##1 local_interrupt_out) else $error("Mailbox interrupt missing");
	local_system_error_out_a: assert property (@(posedge clock) disable iff (!rst_n)
		ctl_r[DFT_B_SERR_LOCAL] && pci_abort |=> local_system_error_out) else $error("Local error missing");
	local_system_error_out_pci_a: assert property (@(posedge clock) disable iff (!rst_n)
		ctl_r[DFT_B_SERR_PCI] && queue_overflow |=> local_system_error_out) else $error("Overflow error missing");
	req_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		req_ch0_r[0] && !xfer_start[0] |=> req_ch0_r[0]) else $error("Request dropped early");
	req_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		!req_ch0_r[0] && fifo_level.ch0_in_fill >= 7'd4 && thresh_r.ch0_inbound_almost_full == 4'h0
		|=> req_ch0_r[0]) else $error("Request not raised");
	pm_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
		ctl_r[DFT_B_PM_EN] && ctl_r[DFT_B_PM_PEND] && ctl_r[DFT_B_LINT_EN] |=> local_interrupt_out)
		else $error("PM interrupt missing");
endmodule : dft_ctl

// *** src/dft_pkg.sv ***
// Package: register map, field layout and threshold table for the DMA threshold block
package dft_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] DFT_OFF_THRESH    = 8'h00;
	localparam logic [7:0] DFT_OFF_DUAL_UP   = 8'h04;
	localparam logic [7:0] DFT_OFF_INTCTL    = 8'h08;
	localparam logic [7:0] DFT_OFF_IRQ_STAT  = 8'h0C;
	localparam logic [7:0] DFT_OFF_IRQ_MASK  = 8'h10;
	localparam logic [7:0] DFT_OFF_REQ_STAT  = 8'h14;
	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int DFT_B_SERR_LOCAL  = 0;
	localparam int DFT_B_SERR_PCI    = 1;
	localparam int DFT_B_GEN_SERR    = 2;
	localparam int DFT_B_MBOX_EN     = 3;
	localparam int DFT_B_PM_EN       = 4;
	localparam int DFT_B_PM_PEND     = 5;
	localparam int DFT_B_LINT_EN     = 16;
	localparam logic [31:0] DFT_INTCTL_RST = 32'h0001_0000;
	localparam logic [31:0] DFT_INTCTL_WMASK = 32'h0001_001F;
	localparam logic [1:0]  DFT_PM_D0 = 2'h0;
	// ----------------------------------------------------------------
	// Event status bits
	// ----------------------------------------------------------------
	localparam int DFT_EV_MBOX = 0;
	localparam int DFT_EV_PM   = 1;
	localparam int DFT_EV_SERR = 2;
	localparam int DFT_EV_N    = 3;
	localparam int DFT_NCMP    = 8;
	localparam logic [31:0] DFT_ZERO = 32'h0000_0000;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] ch1_inbound_almost_empty;
		logic [3:0] ch1_outbound_almost_full;
		logic [3:0] ch1_outbound_almost_empty;
		logic [3:0] ch1_inbound_almost_full;
		logic [3:0] ch0_inbound_almost_empty;
		logic [3:0] ch0_outbound_almost_full;
		logic [3:0] ch0_outbound_almost_empty;
		logic [3:0] ch0_inbound_almost_full;
	} dft_thresh_t;
	typedef struct packed {
		logic [6:0] ch1_in_fill;
		logic [6:0] ch1_out_free;
		logic [6:0] ch1_out_fill;
		logic [6:0] ch1_in_free;
		logic [6:0] ch0_in_fill;
		logic [6:0] ch0_out_free;
		logic [6:0] ch0_out_fill;
		logic [6:0] ch0_in_free;
	} dft_level_t;
	typedef enum logic [1:0] {
		DFT_IDLE = 2'b01,
		DFT_REQ  = 2'b10
	} dft_req_state_t;
	// Code to longword count
	function automatic logic [6:0] dft_decode(input logic [3:0] code);
		logic [6:0] lw;
		lw = 7'h00;
		unique case (code)
			4'h0: lw = 7'd4;
			4'h1: lw = 7'd8;
			4'h2: lw = 7'd12;
			4'h3: lw = 7'd16;
			4'h4: lw = 7'd20;
			4'h5: lw = 7'd24;
			4'h6: lw = 7'd28;
			4'h7: lw = 7'd32;
			4'h8: lw = 7'd38;
			4'h9: lw = 7'd40;
			4'hA: lw = 7'd44;
			4'hB: lw = 7'd48;
			4'hC: lw = 7'd52;
			4'hD: lw = 7'd58;
			4'hE: lw = 7'd60;
			default: lw = 7'd60;
		endcase
		return lw;
	endfunction : dft_decode
endpackage : dft_pkg

// *** verif/dft_far_end.sv ***
// Far-side bus master model that answers DMA bus requests
`timescale 1ns/1ps
module dft_far_end (
	input  wire logic       clock, // System clock
	input  wire logic       rst_n, // Reset, active low
	input  wire logic [7:0] req,   // Requests, ch1 in top half
	input  wire logic [7:0] dly,   // Cycles before answering
	output logic      [7:0] start  // Transfer begun pulse
);
	// ------------------------
	// Answer held requests
	// ------------------------
	logic [7:0] cnt [8];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			start <= 8'h00;
			cnt   <= '{default: 8'h00};
		end else begin
			for (int i = 0; i < 8; i++) begin
				start[i] <= 1'h0;
				if (req[i] && !start[i]) begin
					if (cnt[i] >= dly) begin
						start[i] <= 1'h1;
						cnt[i]   <= 8'h00;
					end else begin
						cnt[i] <= cnt[i] + 8'h01;
					end
				end
			end
		end
	end
endmodule : dft_far_end

// *** verif/test_dft_ctl.sv ***
// Self-checking bench for the DMA threshold and interrupt control block
`timescale 1ns/1ps
module test_dft_ctl;
	import dft_pkg::*;
	// ------------------------
	// Signals and instances
	// ------------------------
	logic        clock, rst_n, psel, penable, pwrite, pwrite_pci, pready, pslverr, err;
	logic        dual_addr_en, mailbox_write, mailbox_read, lse, pci_serr_out, lint, irq;
	logic [1:0]  power_state;
	logic [4:0]  ev;
	logic [7:0]  paddr, start, dly;
	wire  [7:0]  req;
	logic [31:0] pwdata, prdata, rd, th, dual_addr_upper;
	dft_level_t  fifo_level;
	int          bad_count, checks_done, serr_n;
	int          lw [15] = '{4, 8, 12, 16, 20, 24, 28, 32, 38, 40, 44, 48, 52, 58, 60};
	int          off [8] = '{0, 0, 5, 10, 0, 0, 3, 7};

	dft_ctl i_dft_ctl (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pwrite_pci, .pready, .prdata,
		.pslverr, .fifo_level, .xfer_start(start[3:0]), .xfer_start_ch1(start[7:4]), .req_ch0_r(req[3:0]),
		.req_ch1_r(req[7:4]), .dual_addr_upper, .dual_addr_en, .local_parity_err(ev[0]), .pci_abort(ev[1]),
		.host_serr_seen(ev[2]), .pci_parity_err(ev[3]), .queue_overflow(ev[4]), .mailbox_write, .mailbox_read,
		.power_state, .local_system_error_out(lse), .pci_serr_out, .local_interrupt_out(lint), .irq);
	dft_far_end i_dft_far_end (.clock, .rst_n, .req, .dly, .start);

	always #5 clock = ~clock;
	always @(posedge clock) begin
		if (pci_serr_out === 1'h1) begin
			serr_n <= serr_n + 1;
		end
	end
	// ------------------------
	// Shared tasks
	// ------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		@(posedge clock);
		while (pready !== 1'h1) begin
			@(posedge clock);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask : apb
	task automatic set_lv(input int j);
		int s;
		for (int i = 0; i < 8; i++) begin
			s = (i < 4) ? 3 - i : 11 - i;
			fifo_level[s*7 +: 7] <= 7'(lw[th[i*4 +: 4]] - (i == j ? 0 : 1));
		end
	endtask : set_lv
	task test_done;
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	// ------------------------
	// Scenarios
	// ------------------------
	task t_reset;
		apb(1'h0, DFT_OFF_THRESH, DFT_ZERO);
		chk(rd, DFT_ZERO, "thresh reset");
		apb(1'h0, DFT_OFF_DUAL_UP, DFT_ZERO);
		chk(rd, DFT_ZERO, "upper reset");
		apb(1'h0, DFT_OFF_INTCTL, DFT_ZERO);
		chk(rd, 32'h0001_0000, "ctl reset");
		apb(1'h0, 8'h18, DFT_ZERO);
		chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
	endtask : t_reset
	task t_regs;
		apb(1'h1, DFT_OFF_THRESH, 32'h1234_5601);
		apb(1'h1, 8'h1C, 32'hFFFF_FFFF);
		chk(32'(err), 32'h0000_0001, "unmapped write");
		apb(1'h0, DFT_OFF_THRESH, DFT_ZERO);
		chk(rd, 32'h1234_5601, "thresh rw");
		apb(1'h1, DFT_OFF_DUAL_UP, 32'hA5A5_0001);
		apb(1'h0, DFT_OFF_DUAL_UP, DFT_ZERO);
		chk(rd, dual_addr_upper, "upper out");
		chk({rd[31:1], dual_addr_en}, 32'hA5A5_0001, "upper rw");
		apb(1'h1, DFT_OFF_DUAL_UP, DFT_ZERO);
		chk(32'(dual_addr_en), DFT_ZERO, "single addr");
	endtask : t_regs
	task t_thresh;
		dly <= 8'h06;
		for (int c = 0; c < 15; c++) begin
			for (int i = 0; i < 8; i++) begin
				th[i*4 +: 4] = (i == 1 || i == 4) ? 4'(14 - c) : 4'((c + off[i]) % 15);
			end
			// Levels low while thresholds change, so no stray request
			fifo_level <= '0;
			apb(1'h1, DFT_OFF_THRESH, th);
			for (int j = 0; j < 8; j++) begin
				set_lv(j);
				repeat (2) @(posedge clock);
				chk(32'(req), 32'(1 << j), "req raise");
				set_lv(8);
				repeat (2) @(posedge clock);
				chk(32'(req), 32'(1 << j), "req held");
				repeat (8) @(posedge clock);
				chk(32'(req), DFT_ZERO, "req served");
			end
		end
	endtask : t_thresh
	task t_serr;
		for (int m = 0; m < 4; m++) begin
			apb(1'h1, DFT_OFF_INTCTL, 32'(m) | 32'h0001_0000);
			for (int e = 0; e < 5; e++) begin
				ev[e] <= 1'h1;
				@(posedge clock);
				ev[e] <= 1'h0;
				#1;
				chk(32'(lse), 32'((e < 2) ? m[0] : m[1]), "local error");
				@(posedge clock);
			end
		end
	endtask : t_serr
	task t_gen;
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0004);
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0004);
		@(posedge clock);
		chk(32'(serr_n), 32'h0000_0001, "serr once");
		apb(1'h0, DFT_OFF_IRQ_STAT, DFT_ZERO);
		chk({rd[31:1], irq}, 32'h0000_0004, "stat masked");
		apb(1'h1, DFT_OFF_IRQ_MASK, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0001, "irq on");
		apb(1'h1, DFT_OFF_IRQ_STAT, 32'h0000_0004);
		chk(32'(irq), DFT_ZERO, "irq clear");
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0000);
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0004);
		@(posedge clock);
		chk(32'(serr_n), 32'h0000_0002, "serr again");
	endtask : t_gen
	task t_mbox;
		for (int m = 0; m < 4; m++) begin
			apb(1'h1, DFT_OFF_INTCTL, {15'h0000, m[1], 12'h000, m[0], 3'h0});
			mailbox_write <= 1'h1;
			@(posedge clock);
			mailbox_write <= 1'h0;
			repeat (2) @(posedge clock);
			chk(32'(lint), 32'(m == 3), "mailbox irq");
			mailbox_read <= 1'h1;
			@(posedge clock);
			mailbox_read <= 1'h0;
			repeat (2) @(posedge clock);
			chk(32'(lint), DFT_ZERO, "mailbox clear");
		end
	endtask : t_mbox
	task t_pm;
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0010);
		power_state <= 2'h1;
		repeat (3) @(posedge clock);
		pwrite_pci <= 1'h1;
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0030);
		apb(1'h0, DFT_OFF_INTCTL, DFT_ZERO);
		chk({rd[31:1], lint}, 32'h0001_0031, "pci clear refused");
		pwrite_pci <= 1'h0;
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0030);
		apb(1'h0, DFT_OFF_INTCTL, DFT_ZERO);
		chk({rd[31:1], lint}, 32'h0001_0010, "local clear");
		power_state <= 2'h0;
		repeat (3) @(posedge clock);
		apb(1'h0, DFT_OFF_INTCTL, DFT_ZERO);
		chk({rd[31:1], lint}, 32'h0001_0031, "pm again");
		pwrite_pci <= 1'h1;
		apb(1'h1, DFT_OFF_INTCTL, 32'h0001_0030);
		apb(1'h0, DFT_OFF_INTCTL, DFT_ZERO);
		chk(rd, 32'h0001_0010, "pci clear in d0");
	endtask : t_pm
	// ------------------------
	// Main sequence and watchdog
	// ------------------------
	initial begin
		clock = 1'h0;
		rst_n = 1'h0;
		{psel, penable, pwrite, pwrite_pci, mailbox_write, mailbox_read} = 6'h00;
		{paddr, dly, power_state, ev} = 23'h00_0000;
		pwdata = DFT_ZERO;
		th = DFT_ZERO;
		fifo_level = 56'h00_0000_0000_0000;
		repeat (3) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		t_reset;
		t_regs;
		t_thresh;
		t_serr;
		t_gen;
		t_mbox;
		t_pm;
		test_done;
	end
	initial begin
		#200000;
		bad_count++;
		test_done;
	end
endmodule : test_dft_ctl
